/* hdl/interlock_pkg.sv */
// Shared constants for the array command interlock controller.
// Assumes a single core clock; spacing times are turned into cycles here.
package interlock_pkg;

    // ------------------------------------------------------------------
    // Clock and general sizing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TIMER_W         = 5;
    localparam int unsigned CLASS_N         = 5;
    localparam int unsigned PAGE_OPEN_MAX_NS = 100000;
    localparam int unsigned PRE_TO_OPEN_MIN_CYC = 2;
    localparam int unsigned FORCE_GUARD_CYC = 16;

    // ------------------------------------------------------------------
    // Operation codes (user side and array_cmd_code pins)
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_PAGE_OPEN       = 3'h0,
        OP_PRECHARGE       = 3'h1,
        OP_BLK_WR_UNMASKED = 3'h2,
        OP_BLK_WR_MASKED   = 3'h3,
        OP_BLK_READ        = 3'h4,
        OP_DUP_PAGE        = 3'h5,
        OP_VIDEO           = 3'h6
    } user_op_e;

    // Spacing classes: index order of the tables below
    localparam int unsigned CL_OPEN = 0;
    localparam int unsigned CL_PRE  = 1;
    localparam int unsigned CL_BLK  = 2;
    localparam int unsigned CL_DUP  = 3;
    localparam int unsigned CL_VID  = 4;

    // ------------------------------------------------------------------
    // Least spacing in ns, [earlier class][later class]
    // ------------------------------------------------------------------
    typedef int unsigned ns_tab_t [CLASS_N][CLASS_N];

    localparam ns_tab_t SAME_FAST_NS = '{
        '{ 0, 80, 40, 40, 40}, '{40, 40,  0,  0,  0}, '{ 0, 20, 20, 20, 20},
        '{ 0, 80, 80, 80, 80}, '{ 0, 40, 40, 40, 80}};
    localparam ns_tab_t SAME_SLOW_NS = '{
        '{ 0,104, 40, 52, 52}, '{52, 52,  0,  0,  0}, '{ 0, 26, 26, 26, 26},
        '{ 0,104,104,104,104}, '{ 0, 52, 52, 52,104}};
    localparam ns_tab_t DIFF_FAST_NS = '{
        '{40, 40, 10, 40, 40}, '{10, 10, 10, 10, 10}, '{10, 10, 20, 10, 10},
        '{80, 40, 10, 80, 80}, '{40, 40, 10, 40, 80}};
    localparam ns_tab_t DIFF_SLOW_NS = '{
        '{52, 52, 13, 52, 52}, '{13, 13, 13, 13, 13}, '{13, 13, 26, 13, 13},
        '{104,52, 13,104,104}, '{52, 52, 13, 52,104}};

    // Cycles to hold off after an issue: ceil(ns / period) - 1, floor 0
    function automatic logic [TIMER_W-1:0] hold_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? '0 : TIMER_W'(c - 1);
    endfunction

endpackage

/* hdl/interlock_timer.sv */
// One hold-off down counter of the interlock matrix.
// Assumes load_en is a one-cycle pulse per issued operation.
`timescale 1ns/1ps
module interlock_timer #(
    parameter int unsigned W = 5
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         load_en,
    input  wire logic [W-1:0] load_val,
    output logic              idle
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic [W-1:0] dec;

    // Count down, a new load only ever lengthens the wait
    always_comb begin
        dec      = (cnt_reg == '0) ? '0 : cnt_reg - W'(1);
        cnt_next = dec;
        if (load_en && (load_val > dec)) begin
            cnt_next = load_val;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign idle = (cnt_reg == '0);

endmodule

/* hdl/array_cmd_interlock.sv */
// Host-side command issuer for a four-bank frame-buffer DRAM array port.
// Assumes the user side holds its request stable until req_ready is seen.
// Functional notes
// - Page open to block transfer: 40 ns same bank, 10/13 ns elsewhere.
// - Page open to precharge: 80/104 ns same bank, 40/52 ns elsewhere.
// - Opens on different banks, and open to duplicate: 40/52 ns.
// - Precharge an opened bank no later than 100,000 ns after opening.
// - Precharge to open: 40/52 ns same bank, 10/13 ns elsewhere.
// - Precharge then open on one bank spans at least two clock cycles.
// - Block transfers spaced 20/26 ns on any bank.
// - Block to precharge or duplicate: 20/26 ns same, 10/13 ns elsewhere.
// - Block transfer to open on another bank: 10/13 ns.
// - Precharges: 40/52 same bank, 10/13 elsewhere; to block, duplicate 10/13 elsewhere only.
// - Duplicate to block transfer: 80/104 same bank, 10/13 ns elsewhere.
// - Duplicates 80/104 ns apart; duplicate to open elsewhere 80/104 ns.
// - Duplicate to precharge: 80/104 ns same bank, 40/52 ns elsewhere.
// - Video transfers spaced 80/104 ns on any bank.
// - Video to block transfer: 40/52 ns same bank, 10/13 ns elsewhere.
// - Video to precharge or duplicate 40/52 ns; to open elsewhere too.
// - Open to video 40/52 ns; duplicate to video 80/104 ns, any bank.
// - Block to video 20/26 same, 10/13 elsewhere; precharge to video 10/13 elsewhere.
// - Every block kind, masked, unmasked or read, obeys block spacing.
`timescale 1ns/1ps
module array_cmd_interlock #(
    parameter int unsigned BANK_N            = 4,
    parameter int unsigned ADDR_W            = 9,
    parameter int unsigned PAGE_OPEN_MAX_CYC =
        interlock_pkg::PAGE_OPEN_MAX_NS / interlock_pkg::CLK_PERIOD_NS
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      grade_slow,
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire logic [2:0]                req_op,
    input  wire logic [$clog2(BANK_N)-1:0] req_bank,
    input  wire logic [ADDR_W-1:0]         req_addr,
    output logic                           array_cmd_valid,
    output logic [2:0]                     array_cmd_code,
    output logic [$clog2(BANK_N)-1:0]      array_bank_select,
    output logic [ADDR_W-1:0]              array_addr,
    output logic [BANK_N-1:0]              bank_open,
    output logic                           auto_precharge
);

    // ------------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------------
    localparam int unsigned BS_W  = $clog2(BANK_N);
    localparam int unsigned AGE_W = $clog2(PAGE_OPEN_MAX_CYC + 1);
    localparam int unsigned TW    = interlock_pkg::TIMER_W;
    localparam int unsigned CN    = interlock_pkg::CLASS_N;
    localparam logic [AGE_W-1:0] FORCE_AT =
        AGE_W'(PAGE_OPEN_MAX_CYC - interlock_pkg::FORCE_GUARD_CYC);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [BANK_N-1:0][CN-1:0]  allowed;
    logic                       req_legal;
    logic [2:0]                 req_class;
    logic                       force_pend;
    logic [BS_W-1:0]            force_bank;
    logic                       force_go;
    logic                       user_go;
    logic                       issue;
    logic [2:0]                 issue_class;
    logic [BS_W-1:0]            issue_bank;
    logic [2:0]                 issue_code;
    logic [ADDR_W-1:0]          issue_addr;
    logic [BANK_N-1:0]          overdue;

    logic                       cmd_valid_reg;
    logic                       cmd_valid_next;
    logic [2:0]                 cmd_code_reg;
    logic [2:0]                 cmd_code_next;
    logic [BS_W-1:0]            cmd_bank_reg;
    logic [BS_W-1:0]            cmd_bank_next;
    logic [ADDR_W-1:0]          cmd_addr_reg;
    logic [ADDR_W-1:0]          cmd_addr_next;
    logic                       auto_pre_reg;
    logic                       auto_pre_next;

    logic [BANK_N-1:0]          open_reg;
    logic [BANK_N-1:0]          open_next;
    logic [BANK_N-1:0][AGE_W-1:0] age_reg;
    logic [BANK_N-1:0][AGE_W-1:0] age_next;

    // ------------------------------------------------------------------
    // Request decode: every block kind maps to one spacing class
    // ------------------------------------------------------------------
    always_comb begin
        req_legal = 1'b1;
        req_class = 3'(interlock_pkg::CL_OPEN);
        unique case (req_op)
            interlock_pkg::OP_PAGE_OPEN:       req_class = 3'(interlock_pkg::CL_OPEN);
            interlock_pkg::OP_PRECHARGE:       req_class = 3'(interlock_pkg::CL_PRE);
            interlock_pkg::OP_BLK_WR_UNMASKED,
            interlock_pkg::OP_BLK_WR_MASKED,
            interlock_pkg::OP_BLK_READ:        req_class = 3'(interlock_pkg::CL_BLK);
            interlock_pkg::OP_DUP_PAGE:        req_class = 3'(interlock_pkg::CL_DUP);
            interlock_pkg::OP_VIDEO:           req_class = 3'(interlock_pkg::CL_VID);
            default:                           req_legal = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Open-page age watch: lowest overdue bank gets a forced precharge
    // ------------------------------------------------------------------
    always_comb begin
        force_pend = 1'b0;
        force_bank = '0;
        for (int b = BANK_N - 1; b >= 0; b--) begin
            if (overdue[b]) begin
                force_pend = 1'b1;
                force_bank = BS_W'(b);
            end
        end
    end

    // ------------------------------------------------------------------
    // Issue arbitration: a forced precharge outranks user requests
    // ------------------------------------------------------------------
    always_comb begin
        force_go  = force_pend && allowed[force_bank][interlock_pkg::CL_PRE];
        req_ready = req_legal && !force_pend && allowed[req_bank][req_class];
        user_go   = req_valid && req_ready;
        issue     = force_go || user_go;
        if (force_pend) begin
            issue_class = 3'(interlock_pkg::CL_PRE);
            issue_bank  = force_bank;
            issue_code  = interlock_pkg::OP_PRECHARGE;
            issue_addr  = '0;
        end else begin
            issue_class = req_class;
            issue_bank  = req_bank;
            issue_code  = req_op;
            issue_addr  = req_addr;
        end
    end

    // ------------------------------------------------------------------
    // Interlock matrix: one timer per target bank and later class
    // ------------------------------------------------------------------
    for (genvar c = 0; c < BANK_N; c++) begin : g_bank
        for (genvar y = 0; y < CN; y++) begin : g_cls
            logic [TW-1:0] hold;

            // Hold-off for a later op of class y on bank c, from the op now issued
            always_comb begin
                hold = '0;
                for (int x = 0; x < CN; x++) begin
                    if (issue_class == 3'(x)) begin
                        if (issue_bank == BS_W'(c)) begin
                            hold = grade_slow
                                 ? interlock_pkg::hold_cycles(interlock_pkg::SAME_SLOW_NS[x][y])
                                 : interlock_pkg::hold_cycles(interlock_pkg::SAME_FAST_NS[x][y]);
                        end else begin
                            hold = grade_slow
                                 ? interlock_pkg::hold_cycles(interlock_pkg::DIFF_SLOW_NS[x][y])
                                 : interlock_pkg::hold_cycles(interlock_pkg::DIFF_FAST_NS[x][y]);
                        end
                    end
                end
                // Precharge then open on one bank never closer than two cycles
                if ((y == interlock_pkg::CL_OPEN)
                    && (issue_class == 3'(interlock_pkg::CL_PRE))
                    && (issue_bank == BS_W'(c))
                    && (hold < TW'(interlock_pkg::PRE_TO_OPEN_MIN_CYC - 1))) begin
                    hold = TW'(interlock_pkg::PRE_TO_OPEN_MIN_CYC - 1);
                end
            end

            interlock_timer #(
                .W        (TW)
            ) u_timer (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .load_en  (issue),
                .load_val (hold),
                .idle     (allowed[c][y])
            );
        end
    end

    // ------------------------------------------------------------------
    // Per-bank open flag and open age
    // ------------------------------------------------------------------
    for (genvar b = 0; b < BANK_N; b++) begin : g_age
        logic hit;

        // Age restarts on open, clears to zero on precharge
        always_comb begin
            hit         = issue && (issue_bank == BS_W'(b));
            open_next[b] = open_reg[b];
            age_next[b]  = age_reg[b];
            if (open_reg[b] && (age_reg[b] != AGE_W'(PAGE_OPEN_MAX_CYC))) begin
                age_next[b] = age_reg[b] + AGE_W'(1);
            end
            if (hit && (issue_class == 3'(interlock_pkg::CL_OPEN))) begin
                open_next[b] = 1'b1;
                age_next[b]  = '0;
            end else if (hit && (issue_class == 3'(interlock_pkg::CL_PRE))) begin
                open_next[b] = 1'b0;
                age_next[b]  = '0;
            end
        end

        assign overdue[b] = open_reg[b] && (age_reg[b] >= FORCE_AT);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            open_reg <= '0;
            age_reg  <= '0;
        end else begin
            open_reg <= open_next;
            age_reg  <= age_next;
        end
    end

    // ------------------------------------------------------------------
    // Array command pins: one registered command per issue cycle
    // ------------------------------------------------------------------
    always_comb begin
        cmd_valid_next = issue;
        cmd_code_next  = cmd_code_reg;
        cmd_bank_next  = cmd_bank_reg;
        cmd_addr_next  = cmd_addr_reg;
        auto_pre_next  = force_go;
        if (issue) begin
            cmd_code_next = issue_code;
            cmd_bank_next = issue_bank;
            cmd_addr_next = issue_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg  <= 3'h0;
            cmd_bank_reg  <= '0;
            cmd_addr_reg  <= '0;
            auto_pre_reg  <= 1'b0;
        end else begin
            cmd_valid_reg <= cmd_valid_next;
            cmd_code_reg  <= cmd_code_next;
            cmd_bank_reg  <= cmd_bank_next;
            cmd_addr_reg  <= cmd_addr_next;
            auto_pre_reg  <= auto_pre_next;
        end
    end

    // Outputs straight from flip-flops
    assign array_cmd_valid   = cmd_valid_reg;
    assign array_cmd_code    = cmd_code_reg;
    assign array_bank_select = cmd_bank_reg;
    assign array_addr        = cmd_addr_reg;
    assign bank_open         = open_reg;
    assign auto_precharge    = auto_pre_reg;

endmodule

/* verif/array_cmd_interlock_checker.sv */
// Concurrent checks on the ports of the array command interlock controller.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module array_cmd_interlock_checker #(
    parameter int unsigned BANK_N            = 4,
    parameter int unsigned ADDR_W            = 9,
    parameter int unsigned PAGE_OPEN_MAX_CYC = 10000
) (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire logic                      grade_slow,
    input wire logic                      req_valid,
    input wire logic                      req_ready,
    input wire logic [2:0]                req_op,
    input wire logic [$clog2(BANK_N)-1:0] req_bank,
    input wire logic [ADDR_W-1:0]         req_addr,
    input wire logic                      array_cmd_valid,
    input wire logic [2:0]                array_cmd_code,
    input wire logic [$clog2(BANK_N)-1:0] array_bank_select,
    input wire logic [ADDR_W-1:0]         array_addr,
    input wire logic [BANK_N-1:0]         bank_open,
    input wire logic                      auto_precharge
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic        acc = req_valid && req_ready;
    wire logic        blk = req_op inside {3'h2, 3'h3, 3'h4};
    logic      [31:0] age_reg;
    logic      [31:0] age_next;
    // Age of the open page on bank 0
    always_comb begin
        age_next = bank_open[0] ? age_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            age_reg <= 32'h0;
        end else begin
            age_reg <= age_next;
        end
    end
    property p_answer;
        acc |=> array_cmd_valid && !auto_precharge && array_cmd_code == $past(req_op)
            && array_bank_select == $past(req_bank) && array_addr == $past(req_addr);
    endproperty
    a_answer: assert property (p_answer) else $error("command does not follow request");
    property p_no_stray;
        array_cmd_valid && !auto_precharge |-> $past(acc);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("command without request");
    property p_open_blk;
        acc && req_op == 3'h0 && !grade_slow |-> ##3 !(acc && blk && req_bank == $past(req_bank, 3));
    endproperty
    a_open_blk: assert property (p_open_blk) else $error("open to block too close");
    property p_open_pre;
        acc && req_op == 3'h0 && !grade_slow |-> ##7
            !(acc && req_op == 3'h1 && req_bank == $past(req_bank, 7));
    endproperty
    a_open_pre: assert property (p_open_pre) else $error("open to precharge too close");
    property p_pre_open;
        acc && req_op == 3'h1 && grade_slow |-> ##5
            !(acc && req_op == 3'h0 && req_bank == $past(req_bank, 5));
    endproperty
    a_pre_open: assert property (p_pre_open) else $error("precharge to open too close");
    property p_pre_two;
        array_cmd_valid && array_cmd_code == 3'h1 |=>
            !(array_cmd_valid && array_cmd_code == 3'h0 && array_bank_select == $past(array_bank_select));
    endproperty
    a_pre_two: assert property (p_pre_two) else $error("precharge then open in one cycle");
    property p_blk_blk;
        acc && blk |=> !(acc && blk);
    endproperty
    a_blk_blk: assert property (p_blk_blk) else $error("block transfers too close");
    property p_vid_vid;
        acc && req_op == 3'h6 && !grade_slow |-> ##7 !(acc && req_op == 3'h6);
    endproperty
    a_vid_vid: assert property (p_vid_vid) else $error("video transfers too close");
    property p_dup_open;
        acc && req_op == 3'h5 && !grade_slow |-> ##7
            !(acc && req_op == 3'h0 && req_bank != $past(req_bank, 7));
    endproperty
    a_dup_open: assert property (p_dup_open) else $error("duplicate to open too close");
    property p_forced;
        auto_precharge |-> array_cmd_valid && array_cmd_code == 3'h1 && array_addr == '0;
    endproperty
    a_forced: assert property (p_forced) else $error("forced precharge malformed");
    property p_open_limit;
        age_reg <= PAGE_OPEN_MAX_CYC;
    endproperty
    a_open_limit: assert property (p_open_limit) else $error("page left open too long");
endmodule
bind array_cmd_interlock array_cmd_interlock_checker #(
    .BANK_N(BANK_N), .ADDR_W(ADDR_W), .PAGE_OPEN_MAX_CYC(PAGE_OPEN_MAX_CYC)
) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .grade_slow(grade_slow), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
    .array_cmd_valid(array_cmd_valid), .array_cmd_code(array_cmd_code),
    .array_bank_select(array_bank_select), .array_addr(array_addr),
    .bank_open(bank_open), .auto_precharge(auto_precharge)
);

/* verif/array_device_model.sv */
// Behavioural model of the four-bank array port driven by the controller.
// Assumes commands are presented for sampling at a core clock rising edge.
`timescale 1ns/1ps
module array_device_model #(
    parameter int MAXC = 10000
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_valid,
    input  wire logic [2:0] cmd_code,
    input  wire logic [1:0] bank_sel,
    output int              fault_total
);
    logic [3:0] pre_phase;
    logic [3:0] page_live;
    int         age [4];
    // Bank state, sampled once per rising edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_phase <= '0;
            page_live <= '0;
            fault_total <= 0;
            foreach (age[i]) age[i] <= 0;
        end else begin
            pre_phase <= '0; // Second edge: open preparation may start
            for (int i = 0; i < 4; i++) begin
                age[i] <= page_live[i] ? age[i] + 1 : 0;
                if (page_live[i] && age[i] >= MAXC) fault_total <= fault_total + 1;
            end
            if (cmd_valid) begin
                case (cmd_code)
                    3'h0: begin
                        if (pre_phase[bank_sel]) fault_total <= fault_total + 1;
                        page_live[bank_sel] <= 1'b1;
                    end
                    3'h1: begin // Precharge begins at this first edge
                        pre_phase[bank_sel] <= 1'b1;
                        page_live[bank_sel] <= 1'b0;
                    end
                    default: ; // Every block kind shares one path
                endcase
            end
        end
    end
endmodule

/* verif/test_dram_bank_command_interlock.sv */
// Self-checking bench for the array command interlock controller.
// Assumes a 100 MHz core clock and a shortened page-open limit.
`timescale 1ns/1ps
module test_dram_bank_command_interlock;
    localparam int MAXC = 64;
    logic       core_clk;
    logic       rst_n;
    logic       grade_slow;
    logic       req_valid;
    logic       req_ready;
    logic [2:0] req_op;
    logic [1:0] req_bank;
    logic [8:0] req_addr;
    logic       array_cmd_valid;
    logic [2:0] array_cmd_code;
    logic [1:0] array_bank_select;
    logic [8:0] array_addr;
    logic [3:0] bank_open;
    logic       auto_precharge;
    int         err_total;
    int         num_checks;
    int         fault_total;
    int         cyc;
    int         last [4][5];
    int         open_at [4];
    logic [3:0] open_m;
    bit         near;
    logic [13:0] expq [$];
    // Least spacing in ns, fast grade: same bank, then other bank
    int SF [5][5] = '{'{0, 80, 40, 40, 40}, '{40, 40, 0, 0, 0},
        '{0, 20, 20, 20, 20}, '{0, 80, 80, 80, 80}, '{0, 40, 40, 40, 80}};
    int DF [5][5] = '{'{40, 40, 10, 40, 40}, '{10, 10, 10, 10, 10},
        '{10, 10, 20, 10, 10}, '{80, 40, 10, 80, 80}, '{40, 40, 10, 40, 80}};
    array_cmd_interlock #(.PAGE_OPEN_MAX_CYC(MAXC)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .grade_slow(grade_slow), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
        .array_cmd_valid(array_cmd_valid), .array_cmd_code(array_cmd_code),
        .array_bank_select(array_bank_select), .array_addr(array_addr),
        .bank_open(bank_open), .auto_precharge(auto_precharge));
    array_device_model #(.MAXC(MAXC)) u_dev (.core_clk(core_clk), .rst_n(rst_n),
        .cmd_valid(array_cmd_valid), .cmd_code(array_cmd_code), .bank_sel(array_bank_select),
        .fault_total(fault_total));
    function automatic int cls(input logic [2:0] op);
        return (op < 3'h2) ? int'(op) : (op < 3'h5) ? 2 : int'(op) - 2;
    endfunction
    // Cycles needed from class k to class c, slow grade scales by 13/10 except same-bank open to block
    function automatic int need(input int k, input int c, input bit same);
        int ns;
        ns = same ? SF[k][c] : DF[k][c];
        if (grade_slow && !(same && k == 0 && c == 2)) ns = ns * 13 / 10;
        ns = (ns + 9) / 10;
        return (ns < 1) ? 1 : ns;
    endfunction
    function automatic bit ok_at(input int c, input logic [1:0] b, input int t);
        bit ok;
        ok = 1;
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 5; j++)
                if (t - last[i][j] < need(j, c, i == b)) ok = 0;
        return ok;
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        chk("device faults", fault_total, 0);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Reference model: spacing history, open pages, expected commands
    always @(negedge core_clk) begin
        if (!rst_n) begin
            cyc = 0;
            open_m = '0;
            expq.delete();
            foreach (last[i, j]) last[i][j] = -100;
        end else begin
            cyc++;
            if (array_cmd_valid) begin
                chk("spacing", ok_at(cls(array_cmd_code), array_bank_select, cyc), 1);
                if (auto_precharge) chk("forced", {array_cmd_code, array_addr}, 12'h200);
                else if (expq.size() == 0) chk("stray", 1, 0);
                else chk("cmd", {array_cmd_code, array_bank_select, array_addr}, expq.pop_front());
                if (array_cmd_code == 3'h0 && !open_m[array_bank_select]) open_at[array_bank_select] = cyc;
                if (array_cmd_code < 3'h2) open_m[array_bank_select] = (array_cmd_code == 3'h0);
                last[array_bank_select][cls(array_cmd_code)] = cyc;
            end
            chk("bank open", bank_open, open_m);
            near = 0;
            for (int i = 0; i < 4; i++) begin
                if (open_m[i] && cyc - open_at[i] > MAXC) chk("open age", 0, 1);
                if (open_m[i] && cyc - open_at[i] >= MAXC - 24) near = 1;
            end
            if (req_valid && !near)
                chk("ready", req_ready, req_op != 3'h7 && ok_at(cls(req_op), req_bank, cyc + 1));
            if (req_valid && req_ready) expq.push_back({req_op, req_bank, req_addr});
        end
    end
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    // Random traffic in both grades, each legal request held until taken
    initial begin
        logic [2:0] op;
        logic [2:0] lop;
        logic [1:0] bk;
        logic [1:0] lbk;
        int         w;
        err_total = 0;
        num_checks = 0;
        {rst_n, grade_slow, req_valid, req_op, req_bank, req_addr} = '0;
        w = $urandom(1868);
        for (int g = 0; g < 2; g++) begin
            rst_n = 0;
            grade_slow = g[0];
            lop = 3'h7;
            repeat (10) @(posedge core_clk);
            #1 rst_n = 1;
            for (int n = 0; n < 400; n++) begin
                op = 3'($urandom_range(7));
                bk = 2'($urandom);
                if (op == 3'h0 && (open_m[bk] || (lop == 3'h0 && lbk == bk))) op = 3'h1;
                {req_valid, req_op, req_bank, req_addr} = {1'b1, op, bk, 9'($urandom)};
                w = 0;
                do begin
                    @(negedge core_clk);
                    w++;
                end while (!req_ready && w < ((op == 3'h7) ? 3 : 60));
                if (op != 3'h7 && !req_ready) chk("wait", 0, 1);
                lop = req_ready ? op : 3'h7;
                lbk = bk;
                @(posedge core_clk);
                #1;
                if (!req_ready || $urandom_range(3) == 0) begin
                    req_valid = 0;
                    @(posedge core_clk);
                    #1;
                end
            end
        end
        repeat (20) @(posedge core_clk);
        end_sim();
    end
endmodule
